// ==== ccbl_pkg.sv ====
// Constants, types and field layout for the cache buffer and lock control block
`default_nettype none
package ccbl_pkg;
    // Control register field positions, way count and way index width
    localparam int CCBL_BIT_DATA_ON    = 31;
    localparam int CCBL_BIT_WR_PROTECT = 30;
    localparam int CCBL_BIT_SB_ENABLE  = 29;
    localparam int CCBL_BIT_PUSH_KEEP  = 28;
    localparam int CCBL_BIT_DATA_LOCK  = 27;
    localparam int CCBL_BIT_INSTR_LOCK = 15;
    localparam int CCBL_NUM_WAYS       = 4;
    localparam int CCBL_WAY_W          = 2;

    // Reset value and writable-bit mask of the control register
    localparam logic [31:0] CCBL_CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CCBL_CTRL_MASK  = 32'hF800_8000;

    // Way numbers used by allocation
    localparam logic [1:0] CCBL_WAY0 = 2'h0;
    localparam logic [1:0] CCBL_WAY1 = 2'h1;
    localparam logic [1:0] CCBL_WAY2 = 2'h2;
    localparam logic [1:0] CCBL_WAY3 = 2'h3;

    // Effective cache mode of a data write
    typedef enum logic [1:0] {
        CCBL_WT_IMPRECISE = 2'h0,
        CCBL_COPYBACK     = 2'h1,
        CCBL_CI_PRECISE   = 2'h2,
        CCBL_CI_IMPRECISE = 2'h3
    } ccbl_mode_e;

    // One data write presented by the pipeline
    typedef struct packed {
        logic       valid;
        ccbl_mode_e mode;
        logic       regionHit;
    } ccbl_write_s;

    // Routing decision for that write
    typedef struct packed {
        logic toStoreBuf;
        logic toBusDirect;
        logic toCache;
        logic accessError;
    } ccbl_route_s;

    // Line push result
    typedef struct packed {
        logic done;
        logic writeBack;
        logic invalidate;
    } ccbl_push_s;
endpackage : ccbl_pkg
`default_nettype wire

// ==== ccbl_way_alloc.sv ====
// Victim way selection with optional half-cache lock
`timescale 1ns/1ps
`default_nettype none
module ccbl_way_alloc (
    input  wire logic                          mclk,
    input  wire logic                          nrst,
    input  wire logic                          allocReq,
    input  wire logic                          halfLock,
    input  wire logic [ccbl_pkg::CCBL_NUM_WAYS-1:0] wayValid,
    output var  logic                          allocDone,
    output var  logic [ccbl_pkg::CCBL_WAY_W-1:0] allocWay
);
    import ccbl_pkg::*;

    logic [CCBL_WAY_W-1:0] rrCount;
    logic [CCBL_WAY_W-1:0] next_way;
    logic [CCBL_WAY_W-1:0] next_rr;

    // Pick the victim and the next round-robin value
    always_comb begin
        next_rr = rrCount;
        if (halfLock) begin
            if (!wayValid[CCBL_WAY2]) begin
                next_way = CCBL_WAY2;
            end else if (!wayValid[CCBL_WAY3]) begin
                next_way = CCBL_WAY3;
            end else begin
                next_way = rrCount[1] ? CCBL_WAY3 : CCBL_WAY2;
                next_rr  = {~rrCount[1], 1'b0};
            end
        end else begin
            if (!wayValid[CCBL_WAY0]) begin
                next_way = CCBL_WAY0;
            end else if (!wayValid[CCBL_WAY1]) begin
                next_way = CCBL_WAY1;
            end else if (!wayValid[CCBL_WAY2]) begin
                next_way = CCBL_WAY2;
            end else if (!wayValid[CCBL_WAY3]) begin
                next_way = CCBL_WAY3;
            end else begin
                next_way = rrCount;
                next_rr  = rrCount + 2'h1;
            end
        end
    end

    // Register the decision and advance the counter
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rrCount   <= 2'h0;
            allocWay  <= 2'h0;
            allocDone <= 1'b0;
        end else begin
            allocDone <= allocReq;
            if (allocReq) begin
                allocWay <= next_way;
                rrCount  <= next_rr;
            end
        end
    end
endmodule : ccbl_way_alloc
`default_nettype wire

// ==== ccbl_cache_ctrl.sv ====
// Cache control register, buffer drain, write routing and way allocation
// How it works
// - Valid push or store buffer data is written on the next free bus cycle.
// - A needed fill waits until push and store buffers are both empty.
// - Supervisor, no-op and exception hold execution until both buffers drain.
// - Data lock bit keeps data ways 0 and 1 from being reallocated.
// - Instruction lock bit keeps instruction ways 0 and 1 from reallocation.
// - Locked caches allocate way 2 first, then way 3, never 0 or 1.
// - Locked ways still take write hits; only explicit push or invalidate removes.
// - Reset clears the whole control register; cache contents are left alone.
// - Register written by control move and read or written by debug.
// - Bit 31 enables data cache; clear stops it but keeps contents.
// - Bit 30 makes writes outside regions raise an access error.
// - Bit 29 routes imprecise write-through or inhibited writes into store buffer.
// - Precise inhibited accesses always bypass the store buffer.
// - Bit 28 chooses whether a line push leaves the line valid.
// - Unlocked: lowest invalid way, else round-robin way, counter modulo 4.
// - Locked and both valid: counter high bit picks way, counter modulo 2.
`timescale 1ns/1ps
`default_nettype none
module ccbl_cache_ctrl (
    input  wire logic                          mclk,
    input  wire logic                          nrst,
    // Control register access
    input  wire logic                          moveWrite,
    input  wire logic [31:0]                   moveData,
    input  wire logic                          dbgWrite,
    input  wire logic                          dbgRead,
    input  wire logic [31:0]                   dbgWrData,
    output var  logic [31:0]                   dbgRdData,
    output var  logic                          dbgRdValid,
    // Buffer state and bus availability
    input  wire logic                          pushBufValid,
    input  wire logic                          storeBufValid,
    input  wire logic                          busFree,
    output var  logic                          busPushStart,
    output var  logic                          busStoreStart,
    // Fill and synchronisation requests from the pipeline
    input  wire logic                          fillReq,
    input  wire logic                          syncReq,
    output var  logic                          fillStart,
    output var  logic                          pipeStall,
    // Data write routing
    input  wire ccbl_pkg::ccbl_write_s         dataWrite,
    output var  ccbl_pkg::ccbl_route_s         writeRoute,
    // Line push instruction
    input  wire logic                          linePushReq,
    input  wire logic                          lineModified,
    output var  ccbl_pkg::ccbl_push_s          linePush,
    // Allocation requests
    input  wire logic                          dataAllocReq,
    input  wire logic [ccbl_pkg::CCBL_NUM_WAYS-1:0] dataWayValid,
    output var  logic                          dataAllocDone,
    output var  logic [ccbl_pkg::CCBL_WAY_W-1:0] dataAllocWay,
    input  wire logic                          instrAllocReq,
    input  wire logic [ccbl_pkg::CCBL_NUM_WAYS-1:0] instrWayValid,
    output var  logic                          instrAllocDone,
    output var  logic [ccbl_pkg::CCBL_WAY_W-1:0] instrAllocWay,
    // Decoded control outputs
    output var  logic                          dataCacheOn
);
    import ccbl_pkg::*;

    typedef enum logic [1:0] {
        CCBL_RUN,
        CCBL_FILL_WAIT,
        CCBL_SYNC_WAIT
    } ccbl_state_e;

    logic [31:0]  cacheControl;
    ccbl_state_e  state;
    logic         buffersEmpty;
    logic         busOwned;
    logic         dataHalfLock;
    logic         instrHalfLock;
    logic         defaultWriteProtect;
    logic         storeBufferEnable;
    logic         pushKeepValid;

    // Field decode
    assign dataHalfLock        = cacheControl[CCBL_BIT_DATA_LOCK];
    assign instrHalfLock       = cacheControl[CCBL_BIT_INSTR_LOCK];
    assign defaultWriteProtect = cacheControl[CCBL_BIT_WR_PROTECT];
    assign storeBufferEnable   = cacheControl[CCBL_BIT_SB_ENABLE];
    assign pushKeepValid       = cacheControl[CCBL_BIT_PUSH_KEEP];
    assign buffersEmpty        = !pushBufValid && !storeBufValid;
    assign busOwned            = busPushStart || busStoreStart;

    // Control register write port, debug write has the last word
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cacheControl <= CCBL_CTRL_RESET;
        end else begin
            if (dbgWrite) begin
                cacheControl <= dbgWrData & CCBL_CTRL_MASK;
            end else if (moveWrite) begin
                cacheControl <= moveData & CCBL_CTRL_MASK;
            end
        end
    end

    // Debug read returns the register one cycle later
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dbgRdData  <= 32'h0000_0000;
            dbgRdValid <= 1'b0;
        end else begin
            dbgRdValid <= dbgRead;
            if (dbgRead) begin
                dbgRdData <= cacheControl;
            end
        end
    end

    // Cache enable output
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dataCacheOn <= 1'b0;
        end else begin
            dataCacheOn <= cacheControl[CCBL_BIT_DATA_ON];
        end
    end

    // Buffer drain: push buffer first, then store buffer
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            busPushStart  <= 1'b0;
            busStoreStart <= 1'b0;
        end else begin
            busPushStart  <= busFree && !busOwned && pushBufValid;
            busStoreStart <= busFree && !busOwned && !pushBufValid && storeBufValid;
        end
    end

    // Pipeline stall and fill sequencing
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state     <= CCBL_RUN;
            fillStart <= 1'b0;
            pipeStall <= 1'b0;
        end else begin
            fillStart <= 1'b0;
            unique case (state)
                CCBL_RUN: begin
                    if (syncReq && !buffersEmpty) begin
                        state     <= CCBL_SYNC_WAIT;
                        pipeStall <= 1'b1;
                    end else if (fillReq && !buffersEmpty) begin
                        state     <= CCBL_FILL_WAIT;
                        pipeStall <= 1'b1;
                    end else if (fillReq && busFree) begin
                        fillStart <= 1'b1;
                    end else if (fillReq) begin
                        state     <= CCBL_FILL_WAIT;
                        pipeStall <= 1'b1;
                    end
                end
                CCBL_FILL_WAIT: begin
                    if (buffersEmpty && busFree && !busOwned) begin
                        fillStart <= 1'b1;
                        pipeStall <= 1'b0;
                        state     <= CCBL_RUN;
                    end
                end
                CCBL_SYNC_WAIT: begin
                    if (buffersEmpty && !busOwned) begin
                        pipeStall <= 1'b0;
                        state     <= CCBL_RUN;
                    end
                end
                default: begin
                    state     <= CCBL_RUN;
                    pipeStall <= 1'b0;
                end
            endcase
        end
    end

    // Data write routing
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            writeRoute <= '0;
        end else begin
            writeRoute <= '0;
            if (dataWrite.valid) begin
                if (!dataWrite.regionHit && defaultWriteProtect) begin
                    writeRoute.accessError <= 1'b1;
                end else if (dataWrite.mode == CCBL_CI_PRECISE) begin
                    writeRoute.toBusDirect <= 1'b1;
                end else if (dataWrite.mode == CCBL_COPYBACK) begin
                    writeRoute.toCache <= 1'b1;
                end else begin
                    writeRoute.toStoreBuf  <= storeBufferEnable;
                    writeRoute.toBusDirect <= !storeBufferEnable;
                    writeRoute.toCache     <= (dataWrite.mode == CCBL_WT_IMPRECISE);
                end
            end
        end
    end

    // Line push instruction result
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            linePush <= '0;
        end else begin
            linePush.done <= linePushReq;
            if (linePushReq) begin
                linePush.writeBack  <= lineModified;
                linePush.invalidate <= !pushKeepValid;
            end else begin
                linePush.writeBack  <= 1'b0;
                linePush.invalidate <= 1'b0;
            end
        end
    end

    // data ways 0 and 1 locked
    ccbl_way_alloc dataAlloc (
        .mclk     (mclk),
        .nrst     (nrst),
        .allocReq (dataAllocReq),
        .halfLock (dataHalfLock),
        .wayValid (dataWayValid),
        .allocDone(dataAllocDone),
        .allocWay (dataAllocWay)
    );

    ccbl_way_alloc instrAlloc (
        .mclk     (mclk),
        .nrst     (nrst),
        .allocReq (instrAllocReq),
        .halfLock (instrHalfLock),
        .wayValid (instrWayValid),
        .allocDone(instrAllocDone),
        .allocWay (instrAllocWay)
    );
endmodule : ccbl_cache_ctrl
`default_nettype wire

// ==== ccbl_bus_model.sv ====
// Bus controller model that owns the push and store buffers
`timescale 1ns/1ps
`default_nettype none
module ccbl_bus_model (
    input  wire logic mclk,
    input  wire logic nrst,
    input  wire logic slow,
    input  wire logic loadPush,
    input  wire logic loadStore,
    input  wire logic busPushStart,
    input  wire logic busStoreStart,
    output var  logic busFree,
    output var  logic pushBufValid,
    output var  logic storeBufValid
);
    logic [1:0] busy;
    // Bus is offered unless held off or a write cycle is still running
    assign busFree = !slow && busy == 2'h0;
    // Buffers fill on load and empty once their write cycle is started
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            busy <= 2'h0;
            pushBufValid <= 1'h0;
            storeBufValid <= 1'h0;
        end else begin
            if (busPushStart || busStoreStart) busy <= 2'h2;
            else if (busy != 2'h0) busy <= busy - 2'h1;
            if (loadPush) pushBufValid <= 1'h1;
            else if (busPushStart) pushBufValid <= 1'h0;
            if (loadStore) storeBufValid <= 1'h1;
            else if (busStoreStart) storeBufValid <= 1'h0;
        end
    end
endmodule : ccbl_bus_model
`default_nettype wire

// ==== ccbl_cache_ctrl_asserts.sv ====
// Concurrent checks on the cache control block ports
`timescale 1ns/1ps
`default_nettype none
module ccbl_cache_ctrl_asserts (
    input wire logic                  mclk,
    input wire logic                  nrst,
    input wire logic                  moveWrite,
    input wire logic                  dbgWrite,
    input wire logic                  dbgRead,
    input wire logic                  dbgRdValid,
    input wire logic                  busFree,
    input wire logic                  pushBufValid,
    input wire logic                  storeBufValid,
    input wire logic                  busPushStart,
    input wire logic                  busStoreStart,
    input wire logic                  fillReq,
    input wire logic                  syncReq,
    input wire logic                  fillStart,
    input wire logic                  pipeStall,
    input wire logic                  linePushReq,
    input wire logic                  lineModified,
    input wire logic                  dataAllocReq,
    input wire logic                  dataAllocDone,
    input wire logic                  instrAllocReq,
    input wire logic                  instrAllocDone,
    input wire logic                  dataCacheOn,
    input wire logic [31:0]           moveData,
    input wire logic [31:0]           dbgWrData,
    input wire logic [31:0]           dbgRdData,
    input wire logic [1:0]            dataAllocWay,
    input wire logic [1:0]            instrAllocWay,
    input wire ccbl_pkg::ccbl_write_s dataWrite,
    input wire ccbl_pkg::ccbl_route_s writeRoute,
    input wire ccbl_pkg::ccbl_push_s  linePush
);
    import ccbl_pkg::*;
    logic [31:0] ctl;
    logic err;
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // Shadow copy of the control register, debug write first
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) ctl <= CCBL_CTRL_RESET;
        else if (dbgWrite) ctl <= dbgWrData & CCBL_CTRL_MASK;
        else if (moveWrite) ctl <= moveData & CCBL_CTRL_MASK;
    end
    // Write that misses all regions while protected
    assign err = !dataWrite.regionHit && ctl[CCBL_BIT_WR_PROTECT];
    property p_drain;
        (pushBufValid || storeBufValid) && busFree && !busPushStart && !busStoreStart && !fillStart
        |=> busPushStart == $past(pushBufValid) && busStoreStart == $past(!pushBufValid);
    endproperty
    a_drain: assert property (p_drain) else $error("drain start wrong");
    property p_fill; fillStart |-> $past(!pushBufValid && !storeBufValid && busFree); endproperty
    a_fill: assert property (p_fill) else $error("fill with buffers busy");
    property p_stall; (fillReq || syncReq) && (pushBufValid || storeBufValid) |=> pipeStall; endproperty
    a_stall: assert property (p_stall) else $error("no stall");
    property p_err; dataWrite.valid && err |=> writeRoute.accessError; endproperty
    a_err: assert property (p_err) else $error("no access error");
    property p_prec;
        dataWrite.valid && !err && dataWrite.mode == CCBL_CI_PRECISE
        |=> writeRoute.toBusDirect && !writeRoute.toStoreBuf;
    endproperty
    a_prec: assert property (p_prec) else $error("precise write buffered");
    property p_sbuf;
        dataWrite.valid && !err && dataWrite.mode == CCBL_CI_IMPRECISE
        |=> writeRoute.toStoreBuf == $past(ctl[CCBL_BIT_SB_ENABLE]);
    endproperty
    a_sbuf: assert property (p_sbuf) else $error("store buffer routing");
    property p_line;
        linePushReq |=> linePush.done && linePush.writeBack == $past(lineModified)
        && linePush.invalidate == !$past(ctl[CCBL_BIT_PUSH_KEEP]);
    endproperty
    a_line: assert property (p_line) else $error("line push result");
    property p_on; dataCacheOn == $past(ctl[CCBL_BIT_DATA_ON]); endproperty
    a_on: assert property (p_on) else $error("cache enable");
    // data lock keeps ways 0 and 1
    property p_dlock; dataAllocReq && ctl[CCBL_BIT_DATA_LOCK] |=> dataAllocDone && dataAllocWay[1]; endproperty
    a_dlock: assert property (p_dlock) else $error("data locked way used");
    // instruction lock keeps ways 0 and 1
    property p_ilock;
        instrAllocReq && ctl[CCBL_BIT_INSTR_LOCK] |=> instrAllocDone && instrAllocWay[1];
    endproperty
    a_ilock: assert property (p_ilock) else $error("instr locked way used");
    property p_read; dbgRead |=> dbgRdValid && dbgRdData == $past(ctl); endproperty
    a_read: assert property (p_read) else $error("debug read");
endmodule : ccbl_cache_ctrl_asserts
bind ccbl_cache_ctrl ccbl_cache_ctrl_asserts u_ccbl_cache_ctrl_asserts (.*);
`default_nettype wire

// ==== test_cache_buffer_lock_control.sv ====
// Self-checking testbench of the cache control block
`timescale 1ns/1ps
`default_nettype none
module test_cache_buffer_lock_control;
    import ccbl_pkg::*;
    logic mclk = '0, nrst = '0, moveWrite = '0, dbgWrite = '0, dbgRead = '0, fillReq = '0;
    logic syncReq = '0, linePushReq = '0, lineModified = '0, dataAllocReq = '0, instrAllocReq = '0;
    logic slow = '0, loadPush = '0, loadStore = '0;
    logic [31:0] moveData = '0, dbgWrData = '0, dbgRdData;
    logic [3:0] dataWayValid = '0, instrWayValid = '0;
    logic dbgRdValid, busFree, pushBufValid, storeBufValid, busPushStart, busStoreStart;
    logic fillStart, pipeStall, dataAllocDone, instrAllocDone, dataCacheOn;
    logic [1:0] dataAllocWay, instrAllocWay;
    ccbl_write_s dataWrite = '0;
    ccbl_route_s writeRoute;
    ccbl_push_s linePush;
    int failCount = 0, testsRun = 0, cycles = 0;
    ccbl_cache_ctrl u_ccbl_cache_ctrl (.*);
    ccbl_bus_model u_ccbl_bus_model (.*);
    // Clock of 10 ns period
    initial begin
        forever #5 mclk = ~mclk;
    end
    // Cut a hang short
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            failCount++;
            closeOut;
        end
    end
    task closeOut;
        if (failCount == 0 && testsRun > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : closeOut
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        testsRun++;
        if (g !== e) begin
            failCount++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task tick;
        @(negedge mclk);
    endtask : tick
    task regWr(input logic dbg, input logic [31:0] d);
        {dbgWrite, moveWrite, dbgWrData, moveData} = {dbg, !dbg, d, d};
        tick;
        {dbgWrite, moveWrite} = 2'h0;
    endtask : regWr
    task regRd(input logic [31:0] e);
        dbgRead = 1'h1;
        tick;
        dbgRead = 1'h0;
        chk("rdValid", 1, dbgRdValid);
        chk("rdData", e, dbgRdData);
    endtask : regRd
    task t_regs;
        regRd(32'h0);
        chk("cacheOn", 0, dataCacheOn);
        regWr(1'h0, 32'hFFFF_FFFF);
        regRd(CCBL_CTRL_MASK);
        chk("cacheOn", 1, dataCacheOn);
        {dbgWrite, moveWrite, dbgWrData, moveData} = {2'h3, 32'h4000_0000, 32'hFFFF_FFFF};
        tick;
        {dbgWrite, moveWrite} = 2'h0;
        regRd(32'h4000_0000);
    endtask : t_regs
    task t_drain;
        {loadPush, loadStore} = 2'h3;
        tick;
        {loadPush, loadStore} = 2'h0;
        for (int i = 0; i < 8 && (busPushStart | busStoreStart) !== 1'h1; i++) tick;
        chk("pushFirst", 2'h2, {busPushStart, busStoreStart});
        for (int i = 0; i < 8 && busStoreStart !== 1'h1; i++) tick;
        chk("storeNext", 1, busStoreStart);
    endtask : t_drain
    task t_wait(input logic fill);
        slow = 1'h1;
        {loadPush, loadStore} = {fill, !fill};
        tick;
        {loadPush, loadStore, fillReq, syncReq} = {2'h0, fill, !fill};
        tick;
        tick;
        chk("stall", 1, pipeStall);
        chk("earlyFill", 0, fillStart);
        slow = 1'h0;
        for (int i = 0; i < 12 && (fill ? fillStart : !pipeStall) !== 1'h1; i++) tick;
        chk("fillStart", fill, fillStart);
        chk("stallOff", 0, pipeStall);
        chk("drained", 0, {pushBufValid, storeBufValid});
        {fillReq, syncReq} = 2'h0;
        tick;
        // Same request again with empty buffers and a free bus
        {fillReq, syncReq} = {fill, !fill};
        tick;
        chk("fillNow", fill, fillStart);
        chk("noStall", 0, pipeStall);
        {fillReq, syncReq} = 2'h0;
        tick;
    endtask : t_wait
    task t_route;
        ccbl_route_s e;
        for (int k = 0; k < 10; k++) begin
            regWr(1'h0, k < 8 ? {2'h0, k[0], 29'h0} : 32'h4000_0000);
            dataWrite = {1'h1, k[2:1], k == 9 || k[0]};
            tick;
            dataWrite.valid = 1'h0;
            e.toStoreBuf = k < 8 && k[0] && (k[2:1] == 2'h0 || k[2:1] == 2'h3);
            e.toBusDirect = k[2:1] == 2'h2 || (!(k < 8 && k[0]) && k[2:1] != 2'h1);
            e.toCache = k[2:1] < 2'h2;
            e.accessError = k == 8;
            if (k == 8) chk("fault", 1, writeRoute.accessError);
            else chk("route", e, writeRoute);
        end
    endtask : t_route
    task t_push;
        for (int k = 0; k < 2; k++) begin
            regWr(1'h1, {3'h0, k[0], 28'h0});
            {linePushReq, lineModified} = {1'h1, !k[0]};
            tick;
            linePushReq = 1'h0;
            chk("linePush", {1'h1, !k[0], !k[0]}, linePush);
        end
    endtask : t_push
    task t_alloc;
        static logic [3:0] v[14] = '{0, 3, 11, 7, 15, 15, 15, 15, 0, 7, 11, 15, 15, 15};
        static logic [1:0] w[14] = '{0, 2, 2, 3, 0, 1, 2, 3, 2, 3, 2, 2, 3, 2};
        for (int s = 0; s < 2; s++) begin
            regWr(1'h0, 32'h0);
            for (int i = 0; i < 14; i++) begin
                if (i == 8) regWr(1'h0, s ? 32'h0000_8000 : 32'h0800_0000);
                {dataAllocReq, instrAllocReq, dataWayValid, instrWayValid} = {!s[0], s[0], v[i], v[i]};
                tick;
                {dataAllocReq, instrAllocReq} = 2'h0;
                if (s == 0) chk("dataWay", {1'h1, w[i]}, {dataAllocDone, dataAllocWay});
                else chk("instrWay", {1'h1, w[i]}, {instrAllocDone, instrAllocWay});
            end
        end
    endtask : t_alloc
    // Reset, then the scenarios in turn
    initial begin
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        nrst = 1'h1;
        tick;
        t_regs;
        t_drain;
        t_wait(1'h1);
        t_wait(1'h0);
        t_route;
        t_push;
        t_alloc;
        closeOut;
    end
endmodule : test_cache_buffer_lock_control
`default_nettype wire
